// ==== design/hpc_defs.svh ====
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

// APB register byte offsets.
`define HPC_OFF_CTRL     12'h000
`define HPC_OFF_STATUS   12'h004
`define HPC_OFF_ADDR     12'h008
`define HPC_OFF_INT_STAT 12'h00C
`define HPC_OFF_INT_EN   12'h010
`define HPC_OFF_INT_CLR  12'h014

// Control register fields.
`define HPC_CTRL_BUSY_BIT  0
`define HPC_CTRL_HOST_INTERRUPT_N_BIT  1

// Status register fields.
`define HPC_ST_SELECT_BIT  0
`define HPC_ST_WIDE_BIT    1
`define HPC_ST_READY_BIT   2
`define HPC_ST_BUSY_BIT    3

// Event bits in the interrupt status, enable and clear registers.
`define HPC_EV_ADDR_BIT    0
`define HPC_EV_READ_BIT    1
`define HPC_EV_WRITE_BIT   2
`define HPC_EV_COUNT       3

// Reset values.
`define HPC_ADDR_RESET     16'h0000
`define HPC_EV_RESET       3'h0

`endif

// ==== design/hpc_pkg.sv ====
package hpc_pkg;

	// Host access tracking: idle, strobe active, strobe released.
	typedef enum logic [1:0] {
		HPC_IDLE   = 2'b00,
		HPC_ACTIVE = 2'b01,
		HPC_DONE   = 2'b11
	} hpc_access_type;

endpackage

// ==== design/hpc_host_port.sv ====
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_host_port #(
	parameter int ADDR_W = 16
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              chip_reset_n_in,
	input  wire logic              output_disable_n_in,
	input  wire logic              port_select_strap_in,
	input  wire logic              wide_mode_strap_in,
	input  wire logic              port_chip_select_n_in,
	input  wire logic              address_strobe_n_in,
	input  wire logic              data_strobe_n_in,
	input  wire logic              read_not_write_in,
	input  wire logic              byte_order_flag_in,
	input  wire logic [ADDR_W-1:0] host_addr_in,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic                   host_ready_out,
	output logic                   host_ready_oe_out,
	output logic                   host_interrupt_n_out,
	output logic                   host_interrupt_n_oe_out,
	output logic                   pullup_enable_out,
	output logic                   bus_holder_enable_out,
	output logic                   read_strobe_out,
	output logic                   write_strobe_out,
	output logic                   second_byte_out,
	output logic [ADDR_W-1:0]      host_address_reg_out,
	output logic                   irq_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	// First and second stages for all asynchronous control pins.
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	// Host address bus is sampled through two stages as well.
	logic [ADDR_W-1:0] haddr1_ff;
	logic [ADDR_W-1:0] haddr2_ff;

	// Two flip-flops ahead of any logic for every pin input.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			// The chip reset stage starts low, the level that the edge detector expects.
			// A high start would look like a release and capture the straps.
			sync1_ff <= 10'h1FD;
			sync2_ff <= 10'h1FD;
			haddr1_ff <= '0;
			haddr2_ff <= '0;
		end else begin
			sync1_ff <= {chip_reset_n_in, output_disable_n_in, port_select_strap_in,
				wide_mode_strap_in, port_chip_select_n_in, address_strobe_n_in,
				data_strobe_n_in, read_not_write_in, byte_order_flag_in, 1'b1};
			sync2_ff <= sync1_ff;
			haddr1_ff <= host_addr_in;
			haddr2_ff <= haddr1_ff;
		end
	end

	// Synchronised pin levels, read only from the second stage.
	logic chip_reset_n_s;
	logic out_en_s;
	logic sel_strap_s;
	logic wide_strap_s;
	logic cs_n_s;
	logic as_n_s;
	logic ds_n_s;
	logic rnw_s;
	logic bil_s;
	assign chip_reset_n_s = sync2_ff[9];
	assign out_en_s       = sync2_ff[8];
	assign sel_strap_s    = sync2_ff[7];
	assign wide_strap_s   = sync2_ff[6];
	assign cs_n_s         = sync2_ff[5];
	assign as_n_s         = sync2_ff[4];
	assign ds_n_s         = sync2_ff[3];
	assign rnw_s          = sync2_ff[2];
	assign bil_s          = sync2_ff[1];

	// Combined reset: block reset or chip reset pin held low.
	logic in_reset;
	assign in_reset = rst_in || !chip_reset_n_s;

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture.

	// Previous chip reset level, to find its rising edge.
	logic chip_reset_n_d_ff;
	// Latched straps; defaults are deselected and byte-wide.
	logic selected_ff;
	logic wide_ff;

	// Straps are caught only on the rising edge of chip reset and then held.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			chip_reset_n_d_ff <= 1'b0;
			selected_ff <= 1'b0;
			wide_ff <= 1'b0;
		end else begin
			chip_reset_n_d_ff <= chip_reset_n_s;
			if (chip_reset_n_s && !chip_reset_n_d_ff) begin
				selected_ff <= sel_strap_s;
				wide_ff <= wide_strap_s;
			end
		end
	end

	// Deselected port enables pull-ups and bus holders.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pullup_enable_out <= 1'b1;
			bus_holder_enable_out <= 1'b1;
		end else begin
			pullup_enable_out <= !selected_ff;
			bus_holder_enable_out <= !selected_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host access tracking.

	// Previous address strobe level, for its falling edge.
	logic as_n_d_ff;
	// Access state.
	hpc_pkg::hpc_access_type state_ff;
	// Direction of the access in flight.
	logic rnw_ff;

	// An access is live while chip select and data strobe are both low.
	logic access_live;
	assign access_live = selected_ff && !in_reset && !cs_n_s && !ds_n_s;

	// Address latch on falling edge of the address strobe.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			as_n_d_ff <= 1'b1;
			host_address_reg_out <= `HPC_ADDR_RESET;
		end else begin
			as_n_d_ff <= as_n_s;
			if (selected_ff && !in_reset && !as_n_s && as_n_d_ff) begin
				host_address_reg_out <= haddr2_ff;
			end
		end
	end

	// Access state machine with direction and byte order capture.
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			state_ff <= hpc_pkg::HPC_IDLE;
			rnw_ff <= 1'b1;
			second_byte_out <= 1'b0;
		end else begin
			unique case (state_ff)
				hpc_pkg::HPC_IDLE: begin
					if (access_live) begin
						state_ff <= hpc_pkg::HPC_ACTIVE;
						rnw_ff <= rnw_s;
						second_byte_out <= !wide_ff && bil_s;
					end
				end
				hpc_pkg::HPC_ACTIVE: begin
					// Access ends when strobe or chip select rises.
					if (!access_live) begin
						state_ff <= hpc_pkg::HPC_DONE;
					end
				end
				hpc_pkg::HPC_DONE: begin
					state_ff <= hpc_pkg::HPC_IDLE;
				end
				default: begin
					state_ff <= hpc_pkg::HPC_IDLE;
				end
			endcase
		end
	end

	// One-cycle strobes at the start of each access, by direction.
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			read_strobe_out <= 1'b0;
			write_strobe_out <= 1'b0;
		end else begin
			read_strobe_out <= (state_ff == hpc_pkg::HPC_IDLE) && access_live && rnw_s;
			write_strobe_out <= (state_ff == hpc_pkg::HPC_IDLE) && access_live && !rnw_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers over APB.

	// Software busy flag holds ready low; software interrupt request.
	logic busy_ff;
	logic host_interrupt_n_req_ff;
	// Interrupt status and enable.
	logic [`HPC_EV_COUNT-1:0] ev_stat_ff;
	logic [`HPC_EV_COUNT-1:0] ev_en_ff;
	// Event sources this cycle.
	logic [`HPC_EV_COUNT-1:0] ev_set;
	assign ev_set = {write_strobe_out, read_strobe_out,
		selected_ff && !in_reset && !as_n_s && as_n_d_ff};

	// Write qualification in the access phase.
	logic wr_en;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;

	// Address decode for the error flag; the read mux decodes on its own.
	function automatic logic hpc_mapped(input logic [11:0] a);
		hpc_mapped = (a == `HPC_OFF_CTRL) || (a == `HPC_OFF_STATUS) ||
			(a == `HPC_OFF_ADDR) || (a == `HPC_OFF_INT_STAT) ||
			(a == `HPC_OFF_INT_EN) || (a == `HPC_OFF_INT_CLR);
	endfunction

	assign pslverr = psel && penable && !hpc_mapped(paddr);

	// Control and enable register writes.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			busy_ff <= 1'b0;
			host_interrupt_n_req_ff <= 1'b0;
			ev_en_ff <= `HPC_EV_RESET;
		end else if (wr_en) begin
			if (paddr == `HPC_OFF_CTRL) begin
				busy_ff <= pwdata[`HPC_CTRL_BUSY_BIT];
				host_interrupt_n_req_ff <= pwdata[`HPC_CTRL_HOST_INTERRUPT_N_BIT];
			end
			if (paddr == `HPC_OFF_INT_EN) begin
				ev_en_ff <= pwdata[`HPC_EV_COUNT-1:0];
			end
		end
	end

	// Sticky event bits; a new event wins over a clear in the same cycle.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ev_stat_ff <= `HPC_EV_RESET;
		end else begin
			if (wr_en && (paddr == `HPC_OFF_INT_CLR)) begin
				ev_stat_ff <= (ev_stat_ff & ~pwdata[`HPC_EV_COUNT-1:0]) | ev_set;
			end else begin
				ev_stat_ff <= ev_stat_ff | ev_set;
			end
		end
	end

	// Read data multiplexer, registered at the setup phase.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`HPC_OFF_CTRL: prdata <= {30'h0, host_interrupt_n_req_ff, busy_ff};
				`HPC_OFF_STATUS: prdata <= {28'h0, (state_ff != hpc_pkg::HPC_IDLE),
					host_ready_out, wide_ff, selected_ff};
				`HPC_OFF_ADDR: prdata <= {{(32-ADDR_W){1'b0}}, host_address_reg_out};
				`HPC_OFF_INT_STAT: prdata <= {29'h0, ev_stat_ff};
				`HPC_OFF_INT_EN: prdata <= {29'h0, ev_en_ff};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Level interrupt toward the local processor.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(ev_stat_ff & ev_en_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host-facing outputs.

	// Ready high in reset; low while an access or busy blocks the next one.
	always_ff @(posedge clock_in) begin
		if (in_reset) begin
			host_ready_out <= 1'b1;
		end else begin
			host_ready_out <= !busy_ff && (state_ff == hpc_pkg::HPC_IDLE);
		end
	end

	// Interrupt held inactive high in reset or in wide mode.
	always_ff @(posedge clock_in) begin
		if (in_reset || wide_ff) begin
			host_interrupt_n_out <= 1'b1;
		end else begin
			host_interrupt_n_out <= !host_interrupt_n_req_ff;
		end
	end

	// Output disable releases both drivers; wide mode releases the interrupt.
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			host_ready_oe_out <= 1'b0;
			host_interrupt_n_oe_out <= 1'b0;
		end else begin
			host_ready_oe_out <= out_en_s;
			host_interrupt_n_oe_out <= out_en_s && !wide_ff;
		end
	end

endmodule

// ==== test/hpc_host_port_sva.sv ====
`timescale 1ns/1ps
// Pin checks on the host side of the port.
module hpc_sva #(parameter int ADDR_W = 16) (
	input wire logic              clock_in, rst_in, chip_reset_n_in, output_disable_n_in,
	input wire logic              port_chip_select_n_in, address_strobe_n_in, read_not_write_in,
	input wire logic [ADDR_W-1:0] host_addr_in, host_address_reg_out,
	input wire logic              host_ready_out, host_ready_oe_out, host_interrupt_n_out,
	input wire logic              host_interrupt_n_oe_out, pullup_enable_out,
	input wire logic              bus_holder_enable_out, read_strobe_out, write_strobe_out,
	input wire logic              port_select_strap_in
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// A selected address strobe held low past the synchroniser.
	sequence s_as_low;
		chip_reset_n_in && !pullup_enable_out && !port_chip_select_n_in
		&& $fell(address_strobe_n_in) ##1 !address_strobe_n_in [*3];
	endsequence
	chk_addr_latch: assert property (s_as_low |=> host_address_reg_out == host_addr_in)
		else $error("address not latched");
	chk_dir_read: assert property (read_strobe_out |-> read_not_write_in && !write_strobe_out)
		else $error("read strobe on a write");
	chk_dir_write: assert property (write_strobe_out |-> !read_not_write_in)
		else $error("write strobe on a read");
	chk_ready_drop: assert property (read_strobe_out || write_strobe_out |=> !host_ready_out)
		else $error("ready stayed high");
	chk_ready_reset: assert property (!chip_reset_n_in [*4] |-> host_ready_out)
		else $error("ready low in reset");
	chk_host_interrupt_n_reset: assert property (!chip_reset_n_in [*4] |-> host_interrupt_n_out)
		else $error("interrupt active in reset");
	chk_off_tristate: assert property (!output_disable_n_in [*4]
		|-> !host_ready_oe_out && !host_interrupt_n_oe_out)
		else $error("driver on while disabled");
	chk_holder_pair: assert property (pullup_enable_out == bus_holder_enable_out)
		else $error("pull-ups and holders differ");
	chk_select_static: assert property (chip_reset_n_in [*6] |-> $stable(pullup_enable_out))
		else $error("select changed while running");
	// Chip reset released and then held high past the synchroniser and strap capture.
	sequence s_release;
		$rose(chip_reset_n_in) ##1 chip_reset_n_in [*4];
	endsequence
	chk_select_strap: assert property (s_release
		|=> pullup_enable_out == !$past(port_select_strap_in, 5))
		else $error("strap not captured at release");
endmodule
bind hpc_host_port hpc_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ==== test/hpc_host_model.sv ====
`timescale 1ns/1ps
// Host processor: one strobed access per request.
module hpc_host_model (
	input wire logic        clock_in, go_in, rnw_in, flag_in, host_ready_in,
	input wire logic [15:0] addr_in,
	output logic            cs_n_out, as_n_out, ds_n_out, rnw_out, flag_out, done_out,
	output logic [15:0]     addr_out
);
	initial begin
		{cs_n_out, as_n_out, ds_n_out, done_out, rnw_out, flag_out} = 6'b111010;
		addr_out = 16'h0000;
		forever begin
			@(posedge clock_in);
			done_out <= 1'b0;
			if (go_in) begin
				// Wait until the port can take the next transfer.
				while (host_ready_in !== 1'b1) @(posedge clock_in);
				cs_n_out <= 1'b0;
				as_n_out <= 1'b0;
				rnw_out <= rnw_in;
				flag_out <= flag_in;
				addr_out <= addr_in;
				repeat (5) @(posedge clock_in);
				as_n_out <= 1'b1;
				ds_n_out <= 1'b0;
				repeat (5) @(posedge clock_in);
				{cs_n_out, ds_n_out} <= 2'b11;
				// A released bus shows the inverse of its last value.
				addr_out <= ~addr_in;
				done_out <= 1'b1;
			end
		end
	end
endmodule

// ==== test/hpc_host_port_tb.sv ====
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_host_port_tb;
	logic clock_in, rst_in, chip_reset_n_in, output_disable_n_in, port_select_strap_in;
	logic wide_mode_strap_in, port_chip_select_n_in, address_strobe_n_in, data_strobe_n_in;
	logic read_not_write_in, byte_order_flag_in, psel, penable, pwrite, pready, pslverr;
	logic host_ready_out, host_ready_oe_out, host_interrupt_n_out, host_interrupt_n_oe_out;
	logic pullup_enable_out, bus_holder_enable_out, read_strobe_out, write_strobe_out;
	logic second_byte_out, irq_out, go, go_rnw, go_flag, done, err;
	logic [15:0] host_addr_in, host_address_reg_out, go_addr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	int bad_count, comparisons, exp_stat, en;
	hpc_host_port dut (.*);
	hpc_host_model host_m (.clock_in(clock_in), .go_in(go), .rnw_in(go_rnw),
		.flag_in(go_flag), .host_ready_in(host_ready_out), .addr_in(go_addr),
		.cs_n_out(port_chip_select_n_in), .as_n_out(address_strobe_n_in),
		.ds_n_out(data_strobe_n_in), .rnw_out(read_not_write_in),
		.flag_out(byte_order_flag_in), .done_out(done), .addr_out(host_addr_in));
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error are taken at the ready edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do @(posedge clock_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_in);
	endtask
	// One random host access, then its events are checked and cleared.
	task host(input logic r);
		int n;
		seed = xs(seed);
		go_rnw <= r;
		go_flag <= seed[3];
		go_addr <= seed[31:16];
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 300) begin
			@(posedge clock_in);
			n++;
		end
		if (n >= 300) bad_count++;
		repeat (4) @(posedge clock_in);
		chk(32'(host_address_reg_out), 32'(seed[31:16]));
		chk(32'(second_byte_out), 32'(seed[3] & ~wide_mode_strap_in));
		exp_stat = r ? 3 : 5;
		apb(1'b0, `HPC_OFF_INT_STAT, 0);
		chk(rd, exp_stat);
		chk(32'(irq_out), 32'(en != 0));
		apb(1'b1, `HPC_OFF_INT_CLR, 32'h0000_0007);
		apb(1'b0, `HPC_OFF_INT_STAT, 0);
		chk(rd | 32'(irq_out), 0);
	endtask
	task print_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#3000000;
		bad_count++;
		print_verdict;
	end
	initial begin
		seed = 32'd21920;
		{rst_in, chip_reset_n_in, output_disable_n_in, port_select_strap_in} = 4'b1011;
		{wide_mode_strap_in, psel, penable, pwrite, go, go_rnw, go_flag} = 7'b0;
		{paddr, pwdata, go_addr, en} = 0;
		repeat (16) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk({host_ready_out, host_interrupt_n_out, pullup_enable_out}, 7);
		apb(1'b0, `HPC_OFF_ADDR, 0);
		chk(rd, 0);
		chip_reset_n_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		port_select_strap_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		chk({pullup_enable_out, bus_holder_enable_out}, 0);
		apb(1'b0, `HPC_OFF_STATUS, 0);
		chk(rd & 32'h0000_0003, 1);
		for (int k = 0; k < 8; k++) begin
			en = k & 4;
			apb(1'b1, `HPC_OFF_INT_EN, en ? 32'h0000_0007 : 0);
			host(seed[0]);
		end
		apb(1'b0, 12'h0FC, 0);
		chk(32'(err), 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, `HPC_OFF_CTRL, 32'h0000_0002);
		repeat (4) @(posedge clock_in);
		chk(32'(host_interrupt_n_out), 0);
		output_disable_n_in <= 1'b0;
		repeat (5) @(posedge clock_in);
		chk({host_ready_oe_out, host_interrupt_n_oe_out}, 0);
		output_disable_n_in <= 1'b1;
		chip_reset_n_in <= 1'b0;
		{port_select_strap_in, wide_mode_strap_in} <= 2'b11;
		repeat (5) @(posedge clock_in);
		chk({host_ready_out, host_interrupt_n_out}, 3);
		chip_reset_n_in <= 1'b1;
		repeat (8) @(posedge clock_in);
		apb(1'b1, `HPC_OFF_CTRL, 32'h0000_0002);
		apb(1'b0, `HPC_OFF_STATUS, 0);
		chk(rd & 32'h0000_0003, 3);
		chk(32'(host_interrupt_n_out), 1);
		host(1'b1);
		print_verdict;
	end
endmodule
